// ===== src/feuc_pkg.sv
// Constants, types and register map of the flash erase and unlock controller
package feuc_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_KEY0 = 8'h04;
  localparam logic [7:0] OFS_OBKEY = 8'h08;
  localparam logic [7:0] OFS_STAT0 = 8'h0C;
  localparam logic [7:0] OFS_CTL0 = 8'h10;
  localparam logic [7:0] OFS_ADDR0 = 8'h14;
  localparam logic [7:0] OFS_KEY1 = 8'h44;
  localparam logic [7:0] OFS_STAT1 = 8'h4C;
  localparam logic [7:0] OFS_CTL1 = 8'h50;
  localparam logic [7:0] OFS_ADDR1 = 8'h54;
  localparam logic [31:0] KEY_FIRST = 32'h45670123;
  localparam logic [31:0] KEY_SECOND = 32'hCDEF89AB;
  // Control register fields
  localparam int CTL_PER = 1;
  localparam int CTL_MER = 2;
  localparam int CTL_OPTION_PROGRAM_BIT = 4;
  localparam int CTL_OPTION_ERASE_BIT = 5;
  localparam int CTL_START = 6;
  localparam int CTL_LK = 7;
  localparam int CTL_OPTION_WRITE_ENABLE_BIT = 9;
  localparam int CTL_ERROR_INTERRUPT_ENABLE = 10;
  localparam int CTL_END_INTERRUPT_ENABLE = 12;
  // Status register fields
  localparam int STAT_BUSY = 0;
  localparam int STAT_WRITE_PROTECT_ERROR_FLAG = 4;
  localparam int STAT_END_FLAG = 5;
  // Address map
  localparam logic [31:0] MAIN_BASE = 32'h08000000;
  localparam logic [31:0] BANK1_BASE = 32'h08080000;
  localparam logic [31:0] MAIN_END = 32'h08300000;
  localparam logic [31:0] FAST_END = 32'h08040000;
  localparam logic [31:0] INFO_BASE = 32'h1FFFB000;
  localparam logic [31:0] OPT_BASE = 32'h1FFFF800;
  localparam logic [31:0] OPT_END = 32'h1FFFF810;
  localparam int PAGE_W = 10;
  localparam int BANK0_SHIFT = 11;
  localparam int BANK1_SHIFT = 12;
  localparam logic [9:0] BANK0_PAGES = 10'h100;
  localparam int PROT_SHIFT = 5;
  localparam int SLOW_FETCH_CYCLES = 8;
  typedef enum logic [1:0] {
    LK_LOCKED = 2'h0,
    LK_HALF = 2'h1,
    LK_OPEN = 2'h3
  } feuc_lock_type;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CHECK = 2'h1,
    ST_RUN = 2'h3
  } feuc_state_type;
  typedef struct packed {
    logic mass;
    logic [1:0] banks;
    logic [9:0] page;
  } feuc_cmd_type;
endpackage

// ===== src/feuc_key_lock.sv
// Two-key unlock sequencer guarding one set of control bits
`timescale 1ns/10ps
`default_nettype none
module feuc_key_lock (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic key_wr_i,
  input wire logic [31:0] key_i,
  input wire logic relock_i,
  output logic unlocked_o,
  output logic bad_o
);
  feuc_pkg::feuc_lock_type state_q;
  feuc_pkg::feuc_lock_type state_d;
  logic bad_d;
  wire first_ok = key_i == feuc_pkg::KEY_FIRST;
  wire second_ok = key_i == feuc_pkg::KEY_SECOND;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      state_q <= feuc_pkg::LK_LOCKED; // [R6]
    else
      state_q <= state_d;
  end

  always_comb
  begin
    state_d = state_q;
    bad_d = 1'b0;
    if (key_wr_i)
    begin
      case (state_q)
        feuc_pkg::LK_LOCKED:
        begin
          state_d = first_ok ? feuc_pkg::LK_HALF : feuc_pkg::LK_LOCKED; // [R7]
          bad_d = !first_ok; // [R9]
        end
        feuc_pkg::LK_HALF:
        begin
          state_d = second_ok ? feuc_pkg::LK_OPEN : feuc_pkg::LK_LOCKED; // [R7]
          bad_d = !second_ok; // [R9]
        end
        default:
        begin
          // Any key write once open is a wrong operation
          state_d = feuc_pkg::LK_LOCKED; // [R9]
          bad_d = 1'b1;
        end
      endcase
    end
    else if (relock_i)
      state_d = feuc_pkg::LK_LOCKED; // [R8]
  end

  assign unlocked_o = state_q == feuc_pkg::LK_OPEN;
  assign bad_o = bad_d;
endmodule
`default_nettype wire

// ===== src/feuc_top.sv
// Flash controller: key unlock, page and mass erase sequencing, fetch timing
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// [R1] Fetches below 256 Kbytes acknowledged without wait
// [R2] Bank zero 2K pages, bank one 4K
// [R3] Pages decoded contiguously, 0 to 895
// [R4] Option block is a distinct sixteen-byte range
// [R5] Erase of boot loader block refused
// [R6] Control locked and lock bit one after reset
// [R7] Two keys in order clear lock bit
// [R8] Writing lock bit one relocks control
// [R9] Wrong key relocks and flags bus error
// [R10] Option key pair sets option write enable
// [R11] Clearing option enable protects option bits
// [R12] Bank one has own key and lock
// [R13] Page erase touches only addressed page
// [R14] Page erase: set bit, address, start; busy
// [R15] End flag set, interrupt if enabled
// [R16] Protected page ignored, error flag set
// [R17] Each bank has its own status
// [R18] Secured bank-one erase needs both addresses
// [R19] Mass erase banks follow mass-erase bits
// [R20] Mass erase sets selected flash all ones
// [R21] Start ignored when locked or busy
// [R22] Busy clears with end or error flag
module feuc_top #(
  parameter int PROT_W = 32,
  parameter int SLOW_FETCH = feuc_pkg::SLOW_FETCH_CYCLES
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic [feuc_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  output logic BUS_ERR_O,
  output logic IRQ_O,
  input wire logic FETCH_REQ_I,
  input wire logic [31:0] FETCH_ADDR_I,
  output logic FETCH_ACK_O,
  input wire logic SEC_PROT_I,
  input wire logic [PROT_W-1:0] PROT_N_I,
  output logic FLASH_ERASE_O,
  output feuc_pkg::feuc_cmd_type FLASH_CMD_O,
  input wire logic FLASH_DONE_I
);
  localparam int CNT_W = $clog2(SLOW_FETCH + 1);

  logic [1:0] unlocked;
  logic [1:0] key_bad;
  logic ob_unlocked;
  logic ob_bad;
  logic [1:0] wr_key;
  logic [1:0] wr_ctl;
  logic [1:0] wr_stat;
  logic [1:0] wr_addr;
  logic [1:0] ctl_we;
  logic [1:0] launch;
  logic [1:0] per_q;
  logic [1:0] mer_q;
  logic [1:0] end_interrupt_enable_q;
  logic [1:0] error_interrupt_enable_q;
  logic [1:0] end_flag_q;
  logic [1:0] write_protect_error_flag_q;
  logic [1:0] busy_q;
  logic [1:0] set_end;
  logic [1:0] set_err;
  logic [1:0] irq_src;
  logic [31:0] addr_q [2];
  logic [31:0] ctl_word [2];
  logic [31:0] stat_word [2];
  logic option_program_bit_q;
  logic option_erase_bit_q;
  feuc_pkg::feuc_state_type state_q;
  feuc_pkg::feuc_state_type state_d;
  feuc_pkg::feuc_cmd_type cmd_q;
  feuc_pkg::feuc_cmd_type cmd_d;
  logic sel_q;
  logic sel_d;
  logic erase_q;
  logic erase_d;
  logic [31:0] rdata_q;
  logic bus_err_q;
  logic irq_q;
  logic ack_q;
  logic fetch_busy_q;
  logic [CNT_W-1:0] fetch_cnt_q;

  // Register decode
  assign wr_key[0] = WR_I && ADDR_I == feuc_pkg::OFS_KEY0;
  assign wr_key[1] = WR_I && ADDR_I == feuc_pkg::OFS_KEY1;
  assign wr_ctl[0] = WR_I && ADDR_I == feuc_pkg::OFS_CTL0;
  assign wr_ctl[1] = WR_I && ADDR_I == feuc_pkg::OFS_CTL1;
  assign wr_stat[0] = WR_I && ADDR_I == feuc_pkg::OFS_STAT0;
  assign wr_stat[1] = WR_I && ADDR_I == feuc_pkg::OFS_STAT1;
  assign wr_addr[0] = WR_I && ADDR_I == feuc_pkg::OFS_ADDR0;
  assign wr_addr[1] = WR_I && ADDR_I == feuc_pkg::OFS_ADDR1;
  wire wr_obkey = WR_I && ADDR_I == feuc_pkg::OFS_OBKEY;
  wire wr_per = WDATA_I[feuc_pkg::CTL_PER];
  wire wr_mer = WDATA_I[feuc_pkg::CTL_MER];
  wire engine_idle = state_q == feuc_pkg::ST_IDLE;
  wire launch_any = |launch;

  // Option bits need their own key pair on top of the control unlock
  feuc_key_lock u_ob_lock (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .key_wr_i(wr_obkey),
    .key_i(WDATA_I),
    .relock_i(ctl_we[0] && !WDATA_I[feuc_pkg::CTL_OPTION_WRITE_ENABLE_BIT]), // [R11]
    .unlocked_o(ob_unlocked), // [R10]
    .bad_o(ob_bad)
  );

  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      option_program_bit_q <= 1'b0;
      option_erase_bit_q <= 1'b0;
    end
    else if (!ob_unlocked)
    begin
      option_program_bit_q <= 1'b0;
      option_erase_bit_q <= 1'b0;
    end
    else if (ctl_we[0])
    begin
      option_program_bit_q <= WDATA_I[feuc_pkg::CTL_OPTION_PROGRAM_BIT]; // [R10]
      option_erase_bit_q <= WDATA_I[feuc_pkg::CTL_OPTION_ERASE_BIT];
    end
  end

  // Mass erase reaches every bank whose mass-erase bit is set
  wire [1:0] launch_mask = wr_mer ? (launch[1] ? {1'b1, mer_q[0]} : {mer_q[1], 1'b1})
    : launch; // [R19]

  // Erase target decode on the started bank's address register
  wire [31:0] chk_addr = sel_q ? addr_q[1] : addr_q[0];
  wire in_main = chk_addr >= feuc_pkg::MAIN_BASE && chk_addr < feuc_pkg::MAIN_END;
  wire in_bank1 = chk_addr >= feuc_pkg::BANK1_BASE; // [R2]
  wire in_info = chk_addr >= feuc_pkg::INFO_BASE && chk_addr < feuc_pkg::OPT_BASE;
  wire in_opt = chk_addr >= feuc_pkg::OPT_BASE && chk_addr < feuc_pkg::OPT_END;
  wire [31:0] off0 = chk_addr - feuc_pkg::MAIN_BASE;
  wire [31:0] off1 = chk_addr - feuc_pkg::BANK1_BASE;
  wire [9:0] page0 = off0[feuc_pkg::BANK0_SHIFT +: feuc_pkg::PAGE_W]; // [R3]
  wire [9:0] page1 = feuc_pkg::BANK0_PAGES + off1[feuc_pkg::BANK1_SHIFT +: feuc_pkg::PAGE_W];
  wire [9:0] chk_page = in_bank1 ? page1 : page0; // [R3]
  wire [4:0] prot_grp = chk_page[feuc_pkg::PROT_SHIFT +: 5];
  wire page_prot = !PROT_N_I[prot_grp];
  wire bank_bad = in_bank1 != sel_q;
  // Secured bank-one erase relies on software mirroring the address
  wire sec_bad = sel_q && SEC_PROT_I && addr_q[0] != addr_q[1]; // [R18]
  wire target_bad = in_info || in_opt || !in_main; // [R4] [R5]
  wire chk_bad = !cmd_q.mass && (target_bad || bank_bad || page_prot || sec_bad); // [R16]

  genvar b;
  generate
    for (b = 0; b < 2; b++)
    begin : g_bank
      feuc_key_lock u_lock (
        .clk_i(CORE_CLK_I),
        .rst_n_i(RST_N_I),
        .key_wr_i(wr_key[b]), // [R12]
        .key_i(WDATA_I),
        .relock_i(wr_ctl[b] && WDATA_I[feuc_pkg::CTL_LK]), // [R8]
        .unlocked_o(unlocked[b]), // [R7]
        .bad_o(key_bad[b])
      );

      assign ctl_we[b] = wr_ctl[b] && unlocked[b]; // [R6]
      // Locked or busy starts are dropped without touching flash
      assign launch[b] = ctl_we[b] && WDATA_I[feuc_pkg::CTL_START] && engine_idle
        && (wr_per || wr_mer); // [R21] [R14]
      assign set_end[b] = state_q == feuc_pkg::ST_RUN && FLASH_DONE_I && cmd_q.banks[b];
      assign set_err[b] = state_q == feuc_pkg::ST_CHECK && chk_bad && sel_q == b;
      assign irq_src[b] = (end_flag_q[b] && end_interrupt_enable_q[b]) || (write_protect_error_flag_q[b] && error_interrupt_enable_q[b]);

      always_ff @(posedge CORE_CLK_I)
      begin
        if (!RST_N_I)
        begin
          per_q[b] <= 1'b0;
          mer_q[b] <= 1'b0;
          end_interrupt_enable_q[b] <= 1'b0;
          error_interrupt_enable_q[b] <= 1'b0;
        end
        else if (ctl_we[b])
        begin
          per_q[b] <= wr_per;
          mer_q[b] <= wr_mer;
          end_interrupt_enable_q[b] <= WDATA_I[feuc_pkg::CTL_END_INTERRUPT_ENABLE];
          error_interrupt_enable_q[b] <= WDATA_I[feuc_pkg::CTL_ERROR_INTERRUPT_ENABLE];
        end
      end

      always_ff @(posedge CORE_CLK_I)
      begin
        if (!RST_N_I)
          addr_q[b] <= 32'h0;
        else if (wr_addr[b])
          addr_q[b] <= WDATA_I; // [R14]
      end

      // Flag set wins over a same-cycle write-one clear
      always_ff @(posedge CORE_CLK_I)
      begin
        if (!RST_N_I)
        begin
          end_flag_q[b] <= 1'b0;
          write_protect_error_flag_q[b] <= 1'b0;
          busy_q[b] <= 1'b0;
        end
        else
        begin
          end_flag_q[b] <= set_end[b]
            || (end_flag_q[b] && !(wr_stat[b] && WDATA_I[feuc_pkg::STAT_END_FLAG])); // [R15]
          write_protect_error_flag_q[b] <= set_err[b]
            || (write_protect_error_flag_q[b] && !(wr_stat[b] && WDATA_I[feuc_pkg::STAT_WRITE_PROTECT_ERROR_FLAG])); // [R16]
          busy_q[b] <= (launch_any && launch_mask[b])
            || (busy_q[b] && !(set_end[b] || set_err[b] || set_end != 2'h0
            || set_err != 2'h0)); // [R22]
        end
      end

      always_comb
      begin
        stat_word[b] = 32'h0;
        stat_word[b][feuc_pkg::STAT_BUSY] = busy_q[b]; // [R17]
        stat_word[b][feuc_pkg::STAT_WRITE_PROTECT_ERROR_FLAG] = write_protect_error_flag_q[b];
        stat_word[b][feuc_pkg::STAT_END_FLAG] = end_flag_q[b];
        ctl_word[b] = 32'h0;
        ctl_word[b][feuc_pkg::CTL_PER] = per_q[b];
        ctl_word[b][feuc_pkg::CTL_MER] = mer_q[b];
        ctl_word[b][feuc_pkg::CTL_LK] = !unlocked[b]; // [R6]
        ctl_word[b][feuc_pkg::CTL_ERROR_INTERRUPT_ENABLE] = error_interrupt_enable_q[b];
        ctl_word[b][feuc_pkg::CTL_END_INTERRUPT_ENABLE] = end_interrupt_enable_q[b];
        if (b == 0)
        begin
          ctl_word[b][feuc_pkg::CTL_OPTION_PROGRAM_BIT] = option_program_bit_q;
          ctl_word[b][feuc_pkg::CTL_OPTION_ERASE_BIT] = option_erase_bit_q;
          ctl_word[b][feuc_pkg::CTL_OPTION_WRITE_ENABLE_BIT] = ob_unlocked; // [R10]
        end
      end
    end
  endgenerate

  // Erase sequencer shared by both banks, one operation at a time
  always_comb
  begin
    state_d = state_q;
    sel_d = sel_q;
    cmd_d = cmd_q;
    erase_d = erase_q;
    case (state_q)
      feuc_pkg::ST_IDLE:
      begin
        if (launch_any)
        begin
          state_d = feuc_pkg::ST_CHECK;
          sel_d = launch[1];
          cmd_d.mass = wr_mer; // [R19]
          cmd_d.banks = launch_mask;
          cmd_d.page = '0;
        end
      end
      feuc_pkg::ST_CHECK:
      begin
        if (chk_bad)
          state_d = feuc_pkg::ST_IDLE; // [R16]
        else
        begin
          state_d = feuc_pkg::ST_RUN;
          erase_d = 1'b1; // [R13] [R20]
          cmd_d.page = cmd_q.mass ? '0 : chk_page;
        end
      end
      feuc_pkg::ST_RUN:
      begin
        if (FLASH_DONE_I)
        begin
          state_d = feuc_pkg::ST_IDLE; // [R15]
          erase_d = 1'b0;
        end
      end
      default:
      begin
        state_d = feuc_pkg::ST_IDLE;
        erase_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      state_q <= feuc_pkg::ST_IDLE;
      sel_q <= 1'b0;
      cmd_q <= '0;
      erase_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      sel_q <= sel_d;
      cmd_q <= cmd_d;
      erase_q <= erase_d;
    end
  end

  // Read mux; key registers read as zero
  wire [31:0] rd_mux = ADDR_I == feuc_pkg::OFS_STAT0 ? stat_word[0]
    : ADDR_I == feuc_pkg::OFS_STAT1 ? stat_word[1]
    : ADDR_I == feuc_pkg::OFS_CTL0 ? ctl_word[0]
    : ADDR_I == feuc_pkg::OFS_CTL1 ? ctl_word[1]
    : ADDR_I == feuc_pkg::OFS_ADDR0 ? addr_q[0]
    : ADDR_I == feuc_pkg::OFS_ADDR1 ? addr_q[1]
    : 32'h0;

  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      rdata_q <= 32'h0;
      bus_err_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      rdata_q <= RD_I ? rd_mux : 32'h0;
      bus_err_q <= key_bad[0] || key_bad[1] || ob_bad; // [R9]
      irq_q <= |irq_src; // [R15] [R16]
    end
  end

  // Fetch timing: fast region answers next cycle, the rest waits
  wire fetch_fast = FETCH_ADDR_I >= feuc_pkg::MAIN_BASE && FETCH_ADDR_I < feuc_pkg::FAST_END;
  wire fetch_take = FETCH_REQ_I && !fetch_busy_q && !ack_q;

  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      ack_q <= 1'b0;
      fetch_busy_q <= 1'b0;
      fetch_cnt_q <= '0;
    end
    else if (fetch_take && fetch_fast)
      ack_q <= 1'b1; // [R1]
    else if (fetch_take)
    begin
      fetch_busy_q <= 1'b1;
      fetch_cnt_q <= CNT_W'(SLOW_FETCH - 1);
    end
    else if (fetch_busy_q && fetch_cnt_q == '0)
    begin
      fetch_busy_q <= 1'b0;
      ack_q <= 1'b1;
    end
    else if (fetch_busy_q)
      fetch_cnt_q <= fetch_cnt_q - 1'b1;
    else
      ack_q <= 1'b0;
  end

  assign RDATA_O = rdata_q;
  assign BUS_ERR_O = bus_err_q;
  assign IRQ_O = irq_q;
  assign FETCH_ACK_O = ack_q;
  assign FLASH_ERASE_O = erase_q;
  assign FLASH_CMD_O = cmd_q;
endmodule
`default_nettype wire

// ===== tb/feuc_flash_model.sv
// Behavioural flash array answering erase requests after a chosen delay
`timescale 1ns/10ps
`default_nettype none
module feuc_flash_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic erase_i,
  input wire logic [3:0] delay_i,
  output logic done_o
);
  logic [3:0] cnt_q;
  // One done pulse per erase; a zero delay answers as soon as possible
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || !erase_i || done_o)
    begin
      cnt_q <= 4'h0;
      done_o <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_q + 4'h1;
      done_o <= (cnt_q == delay_i);
    end
  end
endmodule
`default_nettype wire

// ===== tb/feuc_top_props.sv
// Port-level assertions for the flash controller
`timescale 1ns/10ps
`default_nettype none
module feuc_top_props #(
  parameter int PROT_W = 32,
  parameter int SLOW_FETCH = 8
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic [feuc_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [31:0] RDATA_O,
  input wire logic BUS_ERR_O,
  input wire logic IRQ_O,
  input wire logic FETCH_REQ_I,
  input wire logic [31:0] FETCH_ADDR_I,
  input wire logic FETCH_ACK_O,
  input wire logic SEC_PROT_I,
  input wire logic [PROT_W-1:0] PROT_N_I,
  input wire logic FLASH_ERASE_O,
  input wire feuc_pkg::feuc_cmd_type FLASH_CMD_O,
  input wire logic FLASH_DONE_I
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  wire logic key_adr = ADDR_I inside {feuc_pkg::OFS_KEY0, feuc_pkg::OFS_KEY1, feuc_pkg::OFS_OBKEY};
  wire logic bad_val = WDATA_I != feuc_pkg::KEY_FIRST && WDATA_I != feuc_pkg::KEY_SECOND;
  wire logic fast = FETCH_ADDR_I >= feuc_pkg::MAIN_BASE && FETCH_ADDR_I < feuc_pkg::FAST_END;
  // Fast check ignores busy windows; bench fetches only while idle
  chk_fast_fetch: assert property (
    $rose(FETCH_REQ_I) && fast && !FLASH_ERASE_O |=> FETCH_ACK_O)
    else $error("fast fetch not answered next cycle");
  chk_slow_fetch: assert property (
    $rose(FETCH_REQ_I) && !fast |=> !FETCH_ACK_O [*2])
    else $error("slow fetch answered too early");
  chk_ack_pulse: assert property (FETCH_ACK_O |=> !FETCH_ACK_O)
    else $error("fetch ack longer than one cycle");
  chk_bad_key: assert property (WR_I && key_adr && bad_val |=> BUS_ERR_O)
    else $error("wrong key without bus error");
  chk_err_cause: assert property (
    BUS_ERR_O |-> $past(WR_I) && $past(key_adr))
    else $error("bus error without key write");
  chk_erase_hold: assert property (
    FLASH_ERASE_O && !FLASH_DONE_I |=> FLASH_ERASE_O && $stable(FLASH_CMD_O))
    else $error("erase dropped or changed early");
  chk_erase_end: assert property (FLASH_ERASE_O && FLASH_DONE_I |=> !FLASH_ERASE_O)
    else $error("erase held after done");
  chk_erase_start: assert property (
    $rose(FLASH_ERASE_O) |-> $past(WR_I, 2) && $past(WDATA_I[feuc_pkg::CTL_START], 2))
    else $error("erase without start two cycles back");
  chk_page_range: assert property (
    FLASH_ERASE_O && !FLASH_CMD_O.mass |-> FLASH_CMD_O.page <= 10'h37F)
    else $error("page beyond last page");
  chk_mass_banks: assert property (
    FLASH_ERASE_O && FLASH_CMD_O.mass |-> FLASH_CMD_O.banks != 2'h0)
    else $error("mass erase with no bank");
endmodule
bind feuc_top feuc_top_props #(.PROT_W(PROT_W), .SLOW_FETCH(SLOW_FETCH)) u_props (
  .CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
  .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .BUS_ERR_O(BUS_ERR_O), .IRQ_O(IRQ_O),
  .FETCH_REQ_I(FETCH_REQ_I), .FETCH_ADDR_I(FETCH_ADDR_I), .FETCH_ACK_O(FETCH_ACK_O),
  .SEC_PROT_I(SEC_PROT_I), .PROT_N_I(PROT_N_I), .FLASH_ERASE_O(FLASH_ERASE_O),
  .FLASH_CMD_O(FLASH_CMD_O), .FLASH_DONE_I(FLASH_DONE_I));
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the flash controller with a flash array model
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; $display("MISMATCH %0t line %0d", $time, `__LINE__); end end
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic freq = 1'b0;
  logic [31:0] faddr = 32'h0;
  logic [31:0] prot_n = 32'hFFFFFFFF;
  logic sec = 1'b0;
  logic [3:0] dly = 4'h0;
  logic [31:0] rdata, s, t, a;
  logic berr, irq, ack, erase, done, seen, irq_s;
  feuc_pkg::feuc_cmd_type fcmd, cmd;
  int errors = 0;
  int tests_run = 0;
  always #2 clk = ~clk;
  // Security input driven so the mirrored-address path gets exercised
  feuc_top #(.PROT_W(32), .SLOW_FETCH(2)) dut (.CORE_CLK_I(clk), .RST_N_I(rst_n),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata),
    .BUS_ERR_O(berr), .IRQ_O(irq), .FETCH_REQ_I(freq), .FETCH_ADDR_I(faddr),
    .FETCH_ACK_O(ack), .SEC_PROT_I(sec), .PROT_N_I(prot_n), .FLASH_ERASE_O(erase),
    .FLASH_CMD_O(fcmd), .FLASH_DONE_I(done));
  feuc_flash_model model (.clk_i(clk), .rst_n_i(rst_n), .erase_i(erase), .delay_i(dly),
    .done_o(done));
  function automatic logic [9:0] exp_page(input logic [31:0] x);
    if (x < feuc_pkg::BANK1_BASE)
      return 10'((x - feuc_pkg::MAIN_BASE) >> 11);
    return 10'h100 + 10'((x - feuc_pkg::BANK1_BASE) >> 12);
  endfunction
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    addr <= ad;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    @(posedge clk);
    addr <= ad;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
  // Start an erase and watch the array side for a fixed span
  task automatic go(input logic b, input logic [31:0] x, input logic [31:0] m);
    logic [7:0] c;
    c = b ? feuc_pkg::OFS_CTL1 : feuc_pkg::OFS_CTL0;
    wr(c, m);
    wr(b ? feuc_pkg::OFS_ADDR1 : feuc_pkg::OFS_ADDR0, x);
    wr(c, m | 32'h40);
    seen = 1'b0;
    repeat (40)
    begin
      @(posedge clk);
      if (erase === 1'b1 && !seen)
      begin
        cmd = fcmd;
        seen = 1'b1;
      end
    end
    irq_s = irq;
    rd(b ? feuc_pkg::OFS_STAT1 : feuc_pkg::OFS_STAT0, s);
  endtask
  task automatic fetch(input logic [31:0] x, input int n_exp);
    int n;
    @(posedge clk);
    freq <= 1'b1;
    faddr <= x;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    freq <= 1'b0;
    `CHK(n, n_exp)
  endtask
  task give_verdict;
    if (errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #40000;
    errors++;
    give_verdict();
  end
  initial
  begin
    void'($urandom(32'h39ef));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    fetch(feuc_pkg::MAIN_BASE | ($urandom & 32'h3FFFC), 2);
    fetch(feuc_pkg::FAST_END - 32'h4, 2);
    fetch(feuc_pkg::FAST_END, 4);
    rd(feuc_pkg::OFS_CTL0, s);
    `CHK(s[7], 1'b1)
    rd(feuc_pkg::OFS_CTL1, s);
    `CHK(s[7], 1'b1)
    wr(feuc_pkg::OFS_CTL0, 32'h2);
    rd(feuc_pkg::OFS_CTL0, s);
    `CHK(s[1], 1'b0)
    wr(feuc_pkg::OFS_KEY0, feuc_pkg::KEY_FIRST);
    wr(feuc_pkg::OFS_KEY0, 32'h12345678);
    @(posedge clk);
    `CHK(berr, 1'b1)
    wr(feuc_pkg::OFS_KEY0, feuc_pkg::KEY_SECOND);
    rd(feuc_pkg::OFS_CTL0, s);
    `CHK(s[7], 1'b1)
    wr(feuc_pkg::OFS_KEY0, feuc_pkg::KEY_FIRST);
    wr(feuc_pkg::OFS_KEY0, feuc_pkg::KEY_SECOND);
    rd(feuc_pkg::OFS_CTL0, s);
    `CHK(s[7], 1'b0)
    wr(feuc_pkg::OFS_KEY1, feuc_pkg::KEY_FIRST);
    wr(feuc_pkg::OFS_KEY1, feuc_pkg::KEY_SECOND);
    rd(feuc_pkg::OFS_CTL1, s);
    `CHK(s[7], 1'b0)
    wr(feuc_pkg::OFS_CTL0, 32'h30);
    rd(feuc_pkg::OFS_CTL0, s);
    `CHK(s & 32'h230, 32'h0)
    wr(feuc_pkg::OFS_OBKEY, feuc_pkg::KEY_FIRST);
    wr(feuc_pkg::OFS_OBKEY, feuc_pkg::KEY_SECOND);
    wr(feuc_pkg::OFS_CTL0, 32'h230);
    rd(feuc_pkg::OFS_CTL0, s);
    `CHK(s & 32'h230, 32'h230)
    wr(feuc_pkg::OFS_CTL0, 32'h0);
    rd(feuc_pkg::OFS_CTL0, s);
    `CHK(s & 32'h230, 32'h0)
    for (int i = 0; i < 8; i++)
    begin
      a = i[0] ? feuc_pkg::BANK1_BASE + (($urandom % 640) << 12) + ($urandom & 32'hFFC)
               : feuc_pkg::MAIN_BASE + (($urandom % 256) << 11) + ($urandom & 32'h7FC);
      if (i == 0)
        a = feuc_pkg::BANK1_BASE - 32'h4;
      if (i == 1)
        a = feuc_pkg::MAIN_END - 32'h4;
      dly <= 4'($urandom);
      go(i[0], a, 32'h2);
      `CHK(seen, 1'b1)
      `CHK(cmd.page, exp_page(a))
      `CHK(cmd.mass, 1'b0)
      `CHK(s & 32'h31, 32'h20)
      rd(i[0] ? feuc_pkg::OFS_STAT0 : feuc_pkg::OFS_STAT1, t);
      `CHK(t[5], 1'b0)
      wr(i[0] ? feuc_pkg::OFS_STAT1 : feuc_pkg::OFS_STAT0, 32'h30);
    end
    prot_n <= ~(32'h1 << 9);
    go(1'b1, feuc_pkg::BANK1_BASE + (32'd44 << 12), 32'h402);
    `CHK(seen, 1'b0)
    `CHK(s & 32'h31, 32'h10)
    `CHK(irq_s, 1'b1)
    wr(feuc_pkg::OFS_STAT1, 32'h30);
    prot_n <= 32'hFFFFFFFF;
    // Bank-zero address started from the bank-one register is refused
    go(1'b1, feuc_pkg::MAIN_BASE, 32'h2);
    `CHK(seen, 1'b0)
    `CHK(s & 32'h31, 32'h10)
    wr(feuc_pkg::OFS_STAT1, 32'h30);
    // Secured bank-one erase runs only once software mirrors the address
    sec <= 1'b1;
    a = feuc_pkg::BANK1_BASE + (($urandom % 640) << 12);
    wr(feuc_pkg::OFS_ADDR0, feuc_pkg::MAIN_BASE);
    go(1'b1, a, 32'h2);
    `CHK(seen, 1'b0)
    `CHK(s & 32'h31, 32'h10)
    wr(feuc_pkg::OFS_STAT1, 32'h30);
    wr(feuc_pkg::OFS_ADDR0, a);
    go(1'b1, a, 32'h2);
    `CHK(seen, 1'b1)
    `CHK(cmd.page, exp_page(a))
    wr(feuc_pkg::OFS_STAT1, 32'h30);
    sec <= 1'b0;
    go(1'b0, feuc_pkg::MAIN_BASE, 32'h1004);
    `CHK(seen, 1'b1)
    `CHK(cmd.mass, 1'b1)
    `CHK(cmd.banks, 2'h1)
    `CHK(irq_s, 1'b1)
    wr(feuc_pkg::OFS_STAT0, 32'h30);
    wr(feuc_pkg::OFS_CTL1, 32'h4);
    go(1'b0, feuc_pkg::MAIN_BASE, 32'h4);
    `CHK(cmd.banks, 2'h3)
    `CHK(irq_s, 1'b0)
    wr(feuc_pkg::OFS_STAT0, 32'h30);
    wr(feuc_pkg::OFS_STAT1, 32'h30);
    wr(feuc_pkg::OFS_CTL1, 32'h0);
    go(1'b0, feuc_pkg::INFO_BASE, 32'h2);
    `CHK(seen, 1'b0)
    `CHK(s & 32'h31, 32'h10)
    wr(feuc_pkg::OFS_STAT0, 32'h30);
    go(1'b0, feuc_pkg::OPT_BASE, 32'h2);
    `CHK(seen, 1'b0)
    `CHK(s & 32'h31, 32'h10)
    wr(feuc_pkg::OFS_STAT0, 32'h30);
    wr(feuc_pkg::OFS_CTL0, 32'h80);
    rd(feuc_pkg::OFS_CTL0, s);
    `CHK(s[7], 1'b1)
    go(1'b0, feuc_pkg::MAIN_BASE, 32'h2);
    `CHK(seen, 1'b0)
    rd(8'hF0, s);
    `CHK(s, 32'h0)
    // Open control and option locks, then reset while idle: bank-zero lock and option enable must close again
    wr(feuc_pkg::OFS_KEY0, feuc_pkg::KEY_FIRST);
    wr(feuc_pkg::OFS_KEY0, feuc_pkg::KEY_SECOND);
    wr(feuc_pkg::OFS_OBKEY, feuc_pkg::KEY_FIRST);
    wr(feuc_pkg::OFS_OBKEY, feuc_pkg::KEY_SECOND);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(feuc_pkg::OFS_CTL0, s);
    `CHK(s & 32'h280, 32'h80)
    give_verdict();
  end
endmodule
`default_nettype wire
